// ===== ppwm_measure.sv
// Purpose: 16-bit pulse period / pulse width measurement channel
// Assumes: 10 MHz clk_i; count sources are clock enables on clk_i
// Notes: Registers reached over AXI4-Lite; one interrupt output
// Notes: Overflow flag reads 1 after reset until the mode is written

`timescale 1ns/1ns

module pulse_period_width_measure
	import ppwm_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// Count clock sources (pulses on clk_i)
	input wire logic [3:0] count_src_i,
	// External measurement input
	input wire logic measure_input_pin_i,
	// AXI4-Lite write address
	input wire logic [7:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	// AXI4-Lite write data
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	// AXI4-Lite write response
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	// AXI4-Lite read address
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	// AXI4-Lite read data
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	// Interrupt
	output logic irq_o
);

	// Reset synchroniser
	// Assertion is immediate; release waits two edges so no flop
	// leaves reset in the same cycle as its neighbour sees a clock.
	logic rst_meta; // First stage, read only by rst_sync
	logic rst_sync; // Active-high-released copy
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end
	wire rst_n = rst_sync;

	// Pin synchroniser: two flops before anything looks at it
	// The fixed two-clock delay shifts every edge alike, so it
	// cancels out of each measured interval.
	logic pin_meta;
	logic pin_sync;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
		end else if (ce_i) begin
			pin_meta <= measure_input_pin_i;
			pin_sync <= pin_meta;
		end
	end

	// Software state
	// All of it holds while ce_i is low
	logic [7:0] mode; // Measurement mode register
	logic start; // Count start bit
	logic [15:0] counter; // Live counter
	logic [15:0] result; // Reload register used as buffer
	logic [1:0] status; // Sticky event bits
	logic [1:0] mask; // Interrupt enables
	logic first_pending; // Next transfer is the first after start
	logic pin_prev; // Previous count-clock sample

	// Field decode
	wire measure_mode = {mode[MODE_HI_BIT], mode[MODE_LO_BIT]}
		== MODE_MEASURE;
	wire [1:0] src_sel = mode[SRC_LO_BIT +: 2];
	// Sources are one-cycle enables on clk_i, not separate clocks,
	// so the whole channel stays in a single clock domain.
	wire counting = start & measure_mode; // Channel enabled
	wire tick = count_src_i[src_sel] & counting;
	wire width_type = mode[TYPE_BIT];
	wire rise_sel = mode[EDGE_BIT];

	// Edge detect on count clock samples
	// While stopped the previous sample follows the pin, so a start
	// never sees a stale level as an edge.
	wire rise = pin_sync & ~pin_prev;
	wire fall = ~pin_sync & pin_prev;
	// Period: like edges by bit 2; width: either edge
	wire period_edge = rise_sel ? rise : fall;
	// Width mode takes either edge; each one closes an interval
	wire width_edge = rise | fall;
	wire meas_edge = tick & (width_type ? width_edge : period_edge);
	wire [15:0] next_counter = counter + 16'h0001;
	// A capture on the wrapping tick clears the counter instead, so
	// it does not count as overflow.
	wire wrap = tick & ~meas_edge & (next_counter == COUNT_RESET);
	// Capture event carried as one bundle to the register logic
	capture_t cap;
	assign cap.edge_seen = meas_edge;
	assign cap.value = counter;
	// Width relies on source holding two count clocks

	// AXI write channel: take address and data in either order
	// A half that arrives alone is parked; its ready stays low until
	// the response is taken, so only one write is ever in flight.
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign awready_o = ~aw_held & ~bvalid_o;
	assign wready_o = ~w_held & ~bvalid_o;
	wire aw_fire = awvalid_i & awready_o;
	wire w_fire = wvalid_i & wready_o;
	wire have_aw = aw_held | aw_fire;
	wire have_w = w_held | w_fire;
	wire [7:0] wr_addr = aw_held ? aw_addr : awaddr_i;
	wire [31:0] wr_data = w_held ? w_data : wdata_i;
	wire [3:0] wr_strb = w_held ? w_strb : wstrb_i;
	wire do_write = have_aw & have_w & ~bvalid_o;
	wire wr_lane0 = do_write & wr_strb[0];

	// Write address decode
	// Only byte lane 0 carries register bits; other lanes are ignored
	wire wr_mode = wr_lane0 & (wr_addr == OFS_MODE);
	wire wr_ctrl = wr_lane0 & (wr_addr == OFS_CTRL);
	wire wr_status = wr_lane0 & (wr_addr == OFS_STATUS);
	wire wr_mask = wr_lane0 & (wr_addr == OFS_MASK);
	wire wr_hit = (wr_addr == OFS_MODE) | (wr_addr == OFS_CTRL)
		| (wr_addr == OFS_RESULT) | (wr_addr == OFS_STATUS)
		| (wr_addr == OFS_MASK);
	wire start_rise = wr_ctrl & wdata_i[0] & ~start & w_fire
		| wr_ctrl & w_data[0] & ~start & w_held;

	// Response is held until bready; a new request waits for that
	// Write channel holding registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else if (ce_i) begin
			// Park a half that arrives alone
			if (aw_fire & ~do_write) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr_i;
			end
			if (w_fire & ~do_write) begin
				w_held <= 1'b1;
				w_data <= wdata_i;
				w_strb <= wstrb_i;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid_o <= 1'b1;
				bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready_i) begin
				bvalid_o <= 1'b0;
			end
		end
	end

	// Control registers; hardware set wins over software clear
	// A clear in the cycle of a new event would lose that event, so
	// the set term is ORed in after the clear.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode <= MODE_RESET; // Overflow flag set
			start <= 1'b0;
			mask <= IRQ_RESET;
			status <= IRQ_RESET;
		end else if (ce_i) begin
			// A lane-0 mode write clears overflow unless a wrap sets it in the same cycle
			if (wr_mode)
				mode <= {wr_data[7:6], 1'b0, wr_data[4:0]};
			// Counter reaching zero sets overflow
			if (wrap)
				mode[OVF_BIT] <= 1'b1;
			// Start bit: counting runs only while it is set
			if (wr_ctrl)
				start <= wr_data[0];
			if (wr_mask)
				mask <= wr_data[1:0];
			// Write one to clear, events set
			status <= (status & ~(wr_status ? wr_data[1:0] : 2'h0))
				| {wrap, cap.edge_seen & ~first_pending};
		end
	end

	// Counter, capture and first-transfer tracking
	// The counter keeps its old value across a start, so the first
	// capture after a start holds a stale interval; that is why its
	// interrupt is dropped.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			counter <= COUNT_RESET;
			result <= COUNT_RESET;
			pin_prev <= 1'b0;
			first_pending <= 1'b1;
		end else if (ce_i) begin
			// Count-clock sample; follows pin when idle
			if (tick | ~counting)
				pin_prev <= pin_sync;
			// Capture takes priority over counting on the same tick
			if (cap.edge_seen) begin
				result <= cap.value;
				counter <= COUNT_RESET;
				first_pending <= 1'b0;
			end else if (tick) begin
				counter <= next_counter;
			end
			// Re-arm suppression on each start
			if (start_rise)
				first_pending <= 1'b1;
		end
	end

	// Read decode results, declared ahead of the read channel
	logic [31:0] next_rdata; // Word for the address on offer
	logic rd_hit; // Address maps to a register

	// Read channel: one cycle after address
	// Data is registered at the address handshake, so it stands
	// unchanged until rready is seen, even if the source moves on.
	assign arready_o = ~rvalid_o;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0000_0000;
			rresp_o <= RESP_OKAY;
		end else if (ce_i) begin
			if (arvalid_i & arready_o) begin
				rvalid_o <= 1'b1;
				rdata_o <= next_rdata;
				rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rready_i) begin
				rvalid_o <= 1'b0;
			end
		end
	end

	// Read decode: timer word shows the buffer, not the counter
	// The live counter has no read path at all in this mode.
	always_comb begin
		rd_hit = 1'b1;
		if (araddr_i == OFS_MODE)
			next_rdata = {24'h000000, mode};
		else if (araddr_i == OFS_CTRL)
			next_rdata = {31'h00000000, start};
		else if (araddr_i == OFS_RESULT)
			next_rdata = {16'h0000, result};
		else if (araddr_i == OFS_STATUS)
			next_rdata = {30'h00000000, status};
		else if (araddr_i == OFS_MASK)
			next_rdata = {30'h00000000, mask};
		else begin
			// Unmapped: zero data and an error response
			next_rdata = 32'h0000_0000;
			rd_hit = 1'b0;
		end
	end

	// Level interrupt from unmasked sticky bits
	// Clearing the mask hides a bit without losing it
	assign irq_o = |(status & mask);

endmodule // pulse_period_width_measure

// ===== ppwm_pkg.sv
// Purpose: Constants and types for the pulse period/width measure channel
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word each
// Notes: Offsets are byte addresses

package ppwm_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MASK = 8'h10;

	// Mode register field positions
	localparam int MODE_LO_BIT = 0;
	localparam int MODE_HI_BIT = 1;
	localparam int EDGE_BIT = 2;
	localparam int TYPE_BIT = 3;
	localparam int OVF_BIT = 5;
	localparam int SRC_LO_BIT = 6;

	// Mode code for measurement
	localparam logic [1:0] MODE_MEASURE = 2'h2;

	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h20;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// Status bits: capture event, overflow event
	localparam int ST_CAP_BIT = 0;
	localparam int ST_OVF_BIT = 1;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Capture event carrier
	typedef struct packed {
		logic edge_seen;
		logic [15:0] value;
	} capture_t;

endpackage

// ===== ppwm_props.sv
// Purpose: Bus and interrupt timing checks
// Assumes: ce_i high while checked
// Notes: Bound to the channel
`timescale 1ns/1ns
module ppwm_props
	import ppwm_pkg::*;
(
	// Clock, reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Write side
	input wire logic awvalid_i,
	input wire logic awready_o,
	input wire logic wvalid_i,
	input wire logic wready_o,
	input wire logic bvalid_o,
	// Read side
	input wire logic [7:0] araddr_i,
	input wire logic arvalid_i,
	input wire logic arready_o,
	input wire logic [31:0] rdata_o,
	input wire logic [1:0] rresp_o,
	input wire logic rvalid_o,
	input wire logic rready_i,
	// Interrupt
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wr_answer_a: assert property (awvalid_i && awready_o && wvalid_i
		&& wready_o |=> bvalid_o) else $error("write answer late");
	wr_refuse_a: assert property (bvalid_o |-> !awready_o && !wready_o)
		else $error("write taken while answering");
	rd_answer_a: assert property (arvalid_i && arready_o |=> rvalid_o)
		else $error("read answer late");
	rd_refuse_a: assert property (rvalid_o |-> !arready_o)
		else $error("read taken while answering");
	rd_release_a: assert property (rvalid_o && rready_i |=> !rvalid_o)
		else $error("read answer repeated");
	unmapped_read_a: assert property (arvalid_i && arready_o
		&& araddr_i > OFS_MASK |=> rresp_o == RESP_SLVERR && rdata_o == 0)
		else $error("unmapped read answered");
	result_read_a: assert property (arvalid_i && arready_o
		&& araddr_i == OFS_RESULT |=> rdata_o[31:16] == 16'h0000)
		else $error("result upper bits set");
	irq_drop_a: assert property ($fell(irq_o) |-> $rose(bvalid_o))
		else $error("interrupt dropped without write");
endmodule // ppwm_props

bind pulse_period_width_measure ppwm_props u_props (.clk_i, .nrst_i,
	.awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o, .araddr_i,
	.arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .irq_o);

// ===== ppwm_pulse_src.sv
// Purpose: External pulse source on the measure pin
// Assumes: levels counted in clk_i cycles
// Notes: Idles high while stopped
`timescale 1ns/1ns
module ppwm_pulse_src #(
	parameter int LOW = 10,
	parameter int HIGH = 25
) (
	// Clock, control
	input wire logic clk_i,
	input wire logic run_i,
	// Pin
	output logic pin_o
);
	int cnt = 0; // Cycles into period
	initial pin_o = 1'b1;
	// High then low; each far above two ticks
	always @(posedge clk_i) begin
		cnt <= run_i ? (cnt + 1) % (LOW + HIGH) : 0;
		pin_o <= !run_i || cnt < HIGH;
	end
endmodule // ppwm_pulse_src

// ===== pulse_period_width_measure_test.sv
// Purpose: Self-checking bench for the measure channel
// Assumes: sources 0, 2 tick each cycle, 1, 3 every second
// Notes: Results compared as offsets, the latency cancels
`timescale 1ns/1ns
module pulse_period_width_measure_test import ppwm_pkg::*; ;
	localparam int L = 10, H = 25, P = 35;
	logic clk_i = 0, nrst_i = 0, pin, run = 0;
	logic [3:0] count_src_i = 4'h1;
	logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o, d;
	logic awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0;
	logic rready_i = 0, awready_o, wready_o, bvalid_o, arready_o;
	logic rvalid_o, irq_o;
	logic [1:0] bresp_o, rresp_o, r, b;
	logic [15:0] rp, res;
	int fails = 0, samples_checked = 0, k;
	always #50 clk_i = ~clk_i;
	// Sources 1 and 3 pulse every other cycle, 0 and 2 every cycle
	always @(posedge clk_i)
		count_src_i <= {~count_src_i[3], 1'b1, ~count_src_i[1], 1'b1};
	pulse_period_width_measure DUT (.clk_i, .nrst_i, .ce_i(1'b1),
		.count_src_i, .measure_input_pin_i(pin), .awaddr_i, .awvalid_i,
		.awready_o, .wdata_i, .wstrb_i(4'hF), .wvalid_i, .wready_o,
		.bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
		.rdata_o, .rresp_o, .rvalid_o, .rready_i, .irq_o);
	ppwm_pulse_src #(.LOW(L), .HIGH(H)) src (.clk_i, .run_i(run), .pin_o(pin));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Bounded wait ran out
	task guard;
		if (k >= 50) begin
			fails++;
			conclude;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		awaddr_i <= a;
		wdata_i <= v;
		awvalid_i <= 1;
		wvalid_i <= 1;
		bready_i <= 1;
		for (k = 0; k < 50 && (awvalid_i || wvalid_i || !bvalid_o); k++) begin
			@(posedge clk_i);
			if (awready_o) awvalid_i <= 0;
			if (wready_o) wvalid_i <= 0;
			if (bvalid_o) b = bresp_o;
		end
		bready_i <= 0;
		guard;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		araddr_i <= a;
		arvalid_i <= 1;
		rready_i <= 1;
		for (k = 0; k < 50 && (arvalid_i || !rvalid_o); k++) begin
			@(posedge clk_i);
			if (arready_o) arvalid_i <= 0;
			d = rdata_o;
			r = rresp_o;
		end
		rready_i <= 0;
		guard;
	endtask
	// Start a fresh run; second result returned
	task measure(input logic [7:0] mode, output logic [15:0] v);
		int i;
		run <= 0;
		wr(OFS_MODE, {24'h0, mode});
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STATUS, 32'h3);
		wr(OFS_CTRL, 32'h1);
		run <= 1;
		repeat (H + P - 8) @(posedge clk_i);
		rd(OFS_STATUS);
		if (!mode[3] || mode[1:0] != MODE_MEASURE)
			check(d, 32'h0);
		if (mode[1:0] == MODE_MEASURE) begin
			for (i = 0; i < 60 && !d[0]; i++)
				rd(OFS_STATUS);
			// No capture at all is a hang
			k = d[0] ? 0 : 50;
			guard;
			check(irq_o, 1'b1);
			rd(OFS_RESULT);
			check(d[31:16], 16'h0);
			v = d[15:0];
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1;
		repeat (3) @(posedge clk_i);
		rd(OFS_MODE);
		check(d, 32'h20);
		rd(8'h14);
		check(r, RESP_SLVERR);
		wr(8'h14, 32'h1);
		check(b, RESP_SLVERR);
		wr(OFS_MASK, 32'h1);
		check(b, RESP_OKAY);
		measure(8'h02, rp);
		check(rp, P - 1);
		rd(OFS_MODE);
		check(d, 32'h02);
		measure(8'h06, res);
		check(res, rp);
		measure(8'h82, res);
		check(res, rp);
		// Half-rate ticks land either side of an odd period
		measure(8'h42, res);
		k = res + P - rp;
		check(k == P / 2 || k == P / 2 + 1, 1);
		measure(8'hC2, res);
		k = res + P - rp;
		check(k == P / 2 || k == P / 2 + 1, 1);
		measure(8'h0A, res);
		check(res + P - rp == L || res + P - rp == H, 1);
		measure(8'h00, res);
		run <= 0;
		wr(OFS_MODE, 32'h02);
		wr(OFS_CTRL, 32'h1);
		// Long enough for any start value to wrap
		repeat (65540) @(posedge clk_i);
		rd(OFS_MODE);
		check(d, 32'h22);
		rd(OFS_STATUS);
		check(d[1], 1'b1);
		wr(OFS_MASK, 32'h2);
		check(irq_o, 1'b1);
		wr(OFS_STATUS, 32'h2);
		check(irq_o, 1'b0);
		wr(OFS_MASK, 32'h0);
		check(irq_o, 1'b0);
		conclude;
	end
endmodule // pulse_period_width_measure_test
